/* rtl/pulse_out_pkg.sv */
package pulse_out_pkg;

	localparam int unsigned ADDR_W        = 4;
	localparam int unsigned DATA_W        = 8;
	localparam int unsigned GROUPS        = 4;
	localparam int unsigned GROUP_W       = 4;
	localparam int unsigned OUT_W         = 16;

	// register offsets
	localparam logic [3:0] OFS_ENABLE_HIGH  = 4'h0;
	localparam logic [3:0] OFS_ENABLE_LOW   = 4'h1;
	localparam logic [3:0] OFS_OUTDATA_HIGH = 4'h2;
	localparam logic [3:0] OFS_OUTDATA_LOW  = 4'h3;
	localparam logic [3:0] OFS_STAGED_HIGH  = 4'h4;
	localparam logic [3:0] OFS_STAGED_LOW   = 4'h5;
	localparam logic [3:0] OFS_STAGED_HIGH2 = 4'h6;
	localparam logic [3:0] OFS_STAGED_LOW2  = 4'h7;
	localparam logic [3:0] OFS_PAIR_SPLIT   = 4'h8;

	// field positions of the pair split register
	localparam int unsigned SPLIT_LOW_POS  = 0;
	localparam int unsigned SPLIT_HIGH_POS = 1;

	// reset values
	localparam logic [7:0] RST_ENABLE  = 8'h00;
	localparam logic [7:0] RST_OUTDATA = 8'h00;
	localparam logic [7:0] RST_STAGED  = 8'h00;
	localparam logic [1:0] RST_SPLIT   = 2'h0;

	// read values of positions with no storage
	localparam logic [3:0] NIBBLE_FILL = 4'hF;
	localparam logic [7:0] ALT_IDLE    = 8'hFF;
	localparam logic [7:0] UNMAPPED    = 8'h00;

endpackage

/* rtl/pulse_output_data_path.sv */
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/10ps
// Notes on behaviour
// - sixteen outputs in four 4-bit groups, each group triggered on its own
// - update events come from the 16-bit timebase timer unit
// - enabled bits copy their staged bit when their group trigger fires
// - disabled bits keep their output value on a trigger
// - cpu writes to enabled output bits are ignored
// - cpu writes to disabled output bits store the written value
// - two 8-bit enable registers, high 15..8, low 7..0, reset zero
// - two 8-bit output data registers, reset zero, reads return current outputs
// - staged registers hold next data, copied by each group's trigger
// - split pairs give nibble views; unused nibble reads ones, ignores writes
module pulse_output_data_path (
	input  wire logic        MCLK_IN,     // 250 MHz clock
	input  wire logic        RSTN_IN,     // async reset, active low
	input  wire logic [3:0]  ADDR_IN,     // register address
	input  wire logic [7:0]  WDATA_IN,    // write data
	input  wire logic        WR_IN,       // write strobe
	input  wire logic        RD_IN,       // read strobe
	output logic      [7:0]  RDATA_OUT,   // read data, cycle after strobe
	input  wire logic [3:0]  TRIG_IN,     // per-group trigger pulse from timer
	output logic      [15:0] PULSE_OUT    // pulse output pins
);

	////////////////////////////////////////////////////////////////////////
	// storage

	logic [15:0] enable_q;
	logic [15:0] staged_q;
	logic [15:0] pod_q;
	logic [1:0]  split_q;
	logic [7:0]  rdata_q;
	logic [7:0]  rdata_d;

	// one-hot register selects, shared by the write and read paths
	logic        hit_en_hi;
	logic        hit_en_lo;
	logic        hit_pod_hi;
	logic        hit_pod_lo;
	logic        hit_stg_hi;
	logic        hit_stg_lo;
	logic        hit_stg_hi2;
	logic        hit_stg_lo2;
	logic        hit_split;

	logic        wr_en_hi;
	logic        wr_en_lo;
	logic        wr_pod_hi;
	logic        wr_pod_lo;
	logic [3:0]  wr_stg_nib;

	logic [7:0]  view_hi;
	logic [7:0]  view_lo;
	logic [7:0]  view_hi2;
	logic [7:0]  view_lo2;

	logic [3:0]  grp_trig;
	logic [15:0] trig_bit;
	logic [15:0] pod_wr_bit;
	logic [15:0] pod_load;
	logic [15:0] pod_take;

	////////////////////////////////////////////////////////////////////////
	// address decode

	// one compare chain keeps write and read on the same map
	always_comb begin
		hit_en_hi   = 1'b0;
		hit_en_lo   = 1'b0;
		hit_pod_hi  = 1'b0;
		hit_pod_lo  = 1'b0;
		hit_stg_hi  = 1'b0;
		hit_stg_lo  = 1'b0;
		hit_stg_hi2 = 1'b0;
		hit_stg_lo2 = 1'b0;
		hit_split   = 1'b0;
		if (ADDR_IN == pulse_out_pkg::OFS_ENABLE_HIGH) begin
			hit_en_hi = 1'b1;
		end else if (ADDR_IN == pulse_out_pkg::OFS_ENABLE_LOW) begin
			hit_en_lo = 1'b1;
		end else if (ADDR_IN == pulse_out_pkg::OFS_OUTDATA_HIGH) begin
			hit_pod_hi = 1'b1;
		end else if (ADDR_IN == pulse_out_pkg::OFS_OUTDATA_LOW) begin
			hit_pod_lo = 1'b1;
		end else if (ADDR_IN == pulse_out_pkg::OFS_STAGED_HIGH) begin
			hit_stg_hi = 1'b1;
		end else if (ADDR_IN == pulse_out_pkg::OFS_STAGED_LOW) begin
			hit_stg_lo = 1'b1;
		end else if (ADDR_IN == pulse_out_pkg::OFS_STAGED_HIGH2) begin
			hit_stg_hi2 = 1'b1;
		end else if (ADDR_IN == pulse_out_pkg::OFS_STAGED_LOW2) begin
			hit_stg_lo2 = 1'b1;
		end else if (ADDR_IN == pulse_out_pkg::OFS_PAIR_SPLIT) begin
			hit_split = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// write decode

	always_comb begin
		wr_en_hi   = 1'b0;
		wr_en_lo   = 1'b0;
		wr_pod_hi  = 1'b0;
		wr_pod_lo  = 1'b0;
		wr_stg_nib = 4'h0;
		if (WR_IN) begin
			if (hit_en_hi) begin
				wr_en_hi = 1'b1;
			end else if (hit_en_lo) begin
				wr_en_lo = 1'b1;
			end else if (hit_pod_hi) begin
				wr_pod_hi = 1'b1;
			end else if (hit_pod_lo) begin
				wr_pod_lo = 1'b1;
			end else if (hit_stg_hi) begin
				// split view carries only the upper nibble
				wr_stg_nib[3] = 1'b1;
				wr_stg_nib[2] = ~split_q[pulse_out_pkg::SPLIT_HIGH_POS];
			end else if (hit_stg_lo) begin
				wr_stg_nib[1] = 1'b1;
				wr_stg_nib[0] = ~split_q[pulse_out_pkg::SPLIT_LOW_POS];
			end else if (hit_stg_hi2) begin
				wr_stg_nib[2] = split_q[pulse_out_pkg::SPLIT_HIGH_POS];
			end else if (hit_stg_lo2) begin
				wr_stg_nib[0] = split_q[pulse_out_pkg::SPLIT_LOW_POS];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// enable flags

	always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			enable_q[15:8] <= pulse_out_pkg::RST_ENABLE;
		end else if (wr_en_hi) begin
			enable_q[15:8] <= WDATA_IN;
		end
	end

	always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			enable_q[7:0] <= pulse_out_pkg::RST_ENABLE;
		end else if (wr_en_lo) begin
			enable_q[7:0] <= WDATA_IN;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pair split control

	always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			split_q <= pulse_out_pkg::RST_SPLIT;
		end else if (WR_IN && hit_split) begin
			split_q <= WDATA_IN[1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// group triggers

	// trigger selection happens upstream; each group only sees its own pulse
	genvar g;
	generate
		for (g = 0; g < pulse_out_pkg::GROUPS; g++) begin : g_grp
			assign grp_trig[g] = TRIG_IN[g];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// per-bit staged and output data

	// a trigger in the cycle of a staged write transfers the old staged value
	genvar b;
	generate
		for (b = 0; b < pulse_out_pkg::OUT_W; b++) begin : g_bit
			localparam int unsigned GRP = b / pulse_out_pkg::GROUP_W;
			localparam int unsigned LB  = b % pulse_out_pkg::DATA_W;

			assign trig_bit[b]   = grp_trig[GRP];
			assign pod_wr_bit[b] = (b >= pulse_out_pkg::DATA_W) ? wr_pod_hi : wr_pod_lo;
			// enabled bits are read-only to the cpu; disabled bits ignore triggers
			assign pod_load[b]   = enable_q[b] & trig_bit[b];
			assign pod_take[b]   = ~enable_q[b] & pod_wr_bit[b];

			always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
				if (!RSTN_IN) begin
					staged_q[b] <= pulse_out_pkg::RST_STAGED[LB];
				end else if (wr_stg_nib[GRP]) begin
					staged_q[b] <= WDATA_IN[LB];
				end
			end

			always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
				if (!RSTN_IN) begin
					pod_q[b] <= pulse_out_pkg::RST_OUTDATA[LB];
				end else if (pod_load[b]) begin
					pod_q[b] <= staged_q[b];
				end else if (pod_take[b]) begin
					pod_q[b] <= WDATA_IN[LB];
				end
			end
		end
	endgenerate

	assign PULSE_OUT = pod_q;

	////////////////////////////////////////////////////////////////////////
	// staged views

	// a split pair shows each nibble alone; the other half reads as ones
	always_comb begin
		if (split_q[pulse_out_pkg::SPLIT_HIGH_POS]) begin
			view_hi  = {staged_q[15:12], pulse_out_pkg::NIBBLE_FILL};
			view_hi2 = {pulse_out_pkg::NIBBLE_FILL, staged_q[11:8]};
		end else begin
			view_hi  = staged_q[15:8];
			view_hi2 = pulse_out_pkg::ALT_IDLE;
		end
	end

	always_comb begin
		if (split_q[pulse_out_pkg::SPLIT_LOW_POS]) begin
			view_lo  = {staged_q[7:4], pulse_out_pkg::NIBBLE_FILL};
			view_lo2 = {pulse_out_pkg::NIBBLE_FILL, staged_q[3:0]};
		end else begin
			view_lo  = staged_q[7:0];
			view_lo2 = pulse_out_pkg::ALT_IDLE;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read path

	always_comb begin
		rdata_d = pulse_out_pkg::UNMAPPED;
		if (RD_IN) begin
			if (hit_en_hi) begin
				rdata_d = enable_q[15:8];
			end else if (hit_en_lo) begin
				rdata_d = enable_q[7:0];
			end else if (hit_pod_hi) begin
				rdata_d = pod_q[15:8];
			end else if (hit_pod_lo) begin
				rdata_d = pod_q[7:0];
			end else if (hit_stg_hi) begin
				rdata_d = view_hi;
			end else if (hit_stg_lo) begin
				rdata_d = view_lo;
			end else if (hit_stg_hi2) begin
				rdata_d = view_hi2;
			end else if (hit_stg_lo2) begin
				rdata_d = view_lo2;
			end else if (hit_split) begin
				rdata_d = {6'h00, split_q};
			end
		end
	end

	// zero outside the answer cycle keeps a wired-or bus quiet
	always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			rdata_q <= pulse_out_pkg::UNMAPPED;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign RDATA_OUT = rdata_q;

endmodule

/* tb/pulse_load_model.sv */
`timescale 1ns/10ps
// the pins only feed plain loads; a load sees the level at each rising edge
module pulse_load_model (
	input  wire logic        clk_in,  // sample clock
	input  wire logic [15:0] pins_in, // pulse pins
	output logic      [15:0] seen_out // level seen by the loads
);
	always_ff @(posedge clk_in) begin
		seen_out <= pins_in;
	end
endmodule

/* tb/pulse_output_data_path_sva.sv */
`timescale 1ns/10ps
module pulse_output_data_path_sva (
	input wire logic        MCLK_IN,
	input wire logic        RSTN_IN,
	input wire logic [3:0]  ADDR_IN,
	input wire logic [7:0]  WDATA_IN,
	input wire logic        WR_IN,
	input wire logic        RD_IN,
	input wire logic [7:0]  RDATA_OUT,
	input wire logic [3:0]  TRIG_IN,
	input wire logic [15:0] PULSE_OUT
);
	logic [7:0] en_q;
	logic       wl;
	assign wl = WR_IN && ADDR_IN == 4'h3;
	// low enable byte mirrored from cpu writes; nothing else changes it
	always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) en_q <= 8'h00;
		else if (WR_IN && ADDR_IN == 4'h1) en_q <= WDATA_IN;
	end
	//////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge MCLK_IN); endclocking
	default disable iff (!RSTN_IN);
	AST_RD_IDLE: assert property (!RD_IN |=> RDATA_OUT == 8'h00) else $error("read data not idle");
	AST_OD_LO: assert property (RD_IN && ADDR_IN == 4'h3 |=> RDATA_OUT == $past(PULSE_OUT[7:0]))
		else $error("low data read differs from pins");
	AST_OD_HI: assert property (RD_IN && ADDR_IN == 4'h2 |=> RDATA_OUT == $past(PULSE_OUT[15:8]))
		else $error("high data read differs from pins");
	AST_EN_LO: assert property (RD_IN && ADDR_IN == 4'h1 |=> RDATA_OUT == $past(en_q))
		else $error("low enable read wrong");
	AST_QUIET: assert property (!wl && TRIG_IN[1:0] == 2'h0 |=> $stable(PULSE_OUT[7:0]))
		else $error("low pins moved without cause");
	AST_GROUP: assert property (TRIG_IN == 4'h1 && !wl |=> $stable(PULSE_OUT[7:4]))
		else $error("group 1 moved on group 0 trigger");
	AST_LOCKED: assert property (wl && TRIG_IN[1:0] == 2'h0 |=>
		((PULSE_OUT[7:0] ^ $past(PULSE_OUT[7:0])) & $past(en_q)) == 8'h00) else $error("enabled bit written");
	AST_PRESET: assert property (wl |=> ((PULSE_OUT[7:0] ^ $past(WDATA_IN)) & ~$past(en_q)) == 8'h00)
		else $error("disabled bit not written");
	AST_HOLD_OFF: assert property (TRIG_IN[0] && !wl |=>
		((PULSE_OUT[3:0] ^ $past(PULSE_OUT[3:0])) & ~$past(en_q[3:0])) == 4'h0) else $error("disabled bit moved");
	AST_RESET: assert property ($rose(RSTN_IN) |-> PULSE_OUT == 16'h0000) else $error("pins not cleared");
endmodule
bind pulse_output_data_path pulse_output_data_path_sva u_sva (.MCLK_IN(MCLK_IN), .RSTN_IN(RSTN_IN),
	.ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
	.TRIG_IN(TRIG_IN), .PULSE_OUT(PULSE_OUT));

/* tb/pulse_output_data_path_tb.sv */
`timescale 1ns/10ps
module pulse_output_data_path_tb;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic [3:0]  addr = 4'h0;
	logic [7:0]  wdata = 8'h00;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [3:0]  trig = 4'h0;
	logic [7:0]  rdata;
	logic [15:0] pins;
	logic [15:0] seen;
	int          errors = 0;
	int          compares = 0;
	always #2 clk = ~clk;
	pulse_output_data_path u_dut (.MCLK_IN(clk), .RSTN_IN(rstn), .ADDR_IN(addr), .WDATA_IN(wdata),
		.WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .TRIG_IN(trig), .PULSE_OUT(pins));
	pulse_load_model u_load (.clk_in(clk), .pins_in(pins), .seen_out(seen));
	//////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// read data stands one cycle only, so it is sampled just after that edge
	task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp, input string what);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(what, {8'h00, rdata}, {8'h00, exp});
	endtask
	task automatic pulse(input logic [3:0] g);
		@(posedge clk);
		trig <= g;
		@(posedge clk);
		trig <= 4'h0;
		#1;
	endtask
	//////////////////////////////////////////////////////////////////////////
	task automatic t_low;
		wr_reg(4'h3, 8'hA5);
		rd_reg(4'h3, 8'hA5, "out lo");
		chk("pins", pins, 16'h00A5);
		wr_reg(4'h1, 8'h0F);
		wr_reg(4'h5, 8'h3C);
		wr_reg(4'h3, 8'hFF);
		rd_reg(4'h3, 8'hF5, "out lo");
		pulse(4'h2);
		chk("pins", pins, 16'h00F5);
		pulse(4'h1);
		chk("pins", pins, 16'h00FC);
		@(posedge clk);
		#1 chk("load", seen, 16'h00FC);
	endtask
	task automatic t_high;
		wr_reg(4'h0, 8'hF0);
		wr_reg(4'h4, 8'h96);
		pulse(4'hC);
		chk("pins", pins, 16'h90FC);
		rd_reg(4'h0, 8'hF0, "en hi");
		rd_reg(4'h4, 8'h96, "staged hi");
	endtask
	task automatic t_split;
		rd_reg(4'h6, 8'hFF, "alt view");
		wr_reg(4'h8, 8'h01);
		rd_reg(4'h5, 8'h3F, "split view");
		wr_reg(4'h7, 8'h0A);
		rd_reg(4'h7, 8'hFA, "split view");
		pulse(4'h1);
		chk("pins", pins, 16'h90FA);
	endtask
	// unused nibbles and unsplit alt views must swallow writes
	task automatic t_ignore;
		wr_reg(4'h6, 8'h55);
		rd_reg(4'h4, 8'h96, "staged hi kept");
		wr_reg(4'h5, 8'h7E);
		rd_reg(4'h5, 8'h7F, "split view");
		rd_reg(4'h7, 8'hFA, "split view kept");
	endtask
	// staged write and trigger in one cycle: old staged value goes out
	task automatic t_clash;
		wr_reg(4'h7, 8'h0C);
		@(posedge clk);
		wr <= 1'b1;
		addr <= 4'h7;
		wdata <= 8'h05;
		trig <= 4'h1;
		@(posedge clk);
		wr <= 1'b0;
		trig <= 4'h0;
		#1 chk("pins", pins, 16'h90FC);
		rd_reg(4'h7, 8'hF5, "staged lo");
		pulse(4'h1);
		chk("pins", pins, 16'h90F5);
	endtask
	task automatic t_reset;
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk("pins", pins, 16'h0000);
		@(posedge clk);
		rstn <= 1'b1;
		rd_reg(4'h1, 8'h00, "reset value");
		rd_reg(4'h5, 8'h00, "reset value");
		rd_reg(4'h7, 8'hFF, "reset value");
	endtask
	task automatic give_verdict;
		if (errors == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	//////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		for (int a = 0; a < 4; a++) rd_reg(a[3:0], 8'h00, "reset value");
		t_low;
		t_high;
		t_split;
		t_ignore;
		t_clash;
		t_reset;
		give_verdict;
	end
	// whole sequence needs well under a thousand cycles
	initial begin
		#20000;
		errors++;
		give_verdict;
	end
endmodule
